// ==== shared/fwp_pkg.sv ====
// package: opcodes, counts and reset values for write latch and sector protect
package fwp_pkg;
	localparam logic [7:0] OP_WR_ENABLE = 8'h06;
	localparam logic [7:0] OP_WR_DISABLE = 8'h04;
	localparam logic [7:0] OP_PROTECT = 8'h36;
	localparam logic [7:0] OP_UNPROTECT = 8'h39;
	localparam logic [7:0] OP_PAGE_PROG = 8'h02;
	localparam logic [7:0] OP_ERASE_4K = 8'h20;
	localparam logic [7:0] OP_ERASE_32K = 8'h52;
	localparam logic [7:0] OP_ERASE_64K = 8'hd8;
	localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
	localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
	localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
	localparam int NUM_SECTORS = 16;
	localparam int ADDR_WIDTH = 24;
	localparam int SECTOR_LSB = 16;
	localparam int BYTE_BITS = 8;
	localparam int ADDR_BYTES = 3;
	localparam logic WEL_RESET = 1'b0;
	localparam logic PROTECT_RESET = 1'b1;
	localparam logic [5:0] BITCNT_RESET = 6'h00;
	typedef enum logic [2:0] {
		FWP_IDLE = 3'b001,
		FWP_SHIFT = 3'b010,
		FWP_DONE = 3'b100
	} fwp_state_e;
endpackage

// ==== src/fwp_sync.sv ====
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ns
module fwp_sync #(
	parameter int WIDTH = 3,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic nrst_in,
	// async in, synced out
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;
	logic [WIDTH-1:0] nxt_meta;
	logic [WIDTH-1:0] nxt_sync;

	always_comb begin
		nxt_meta = async_in;
		nxt_sync = meta_ff;
	end

	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			meta_ff <= RESET_VAL;
			sync_ff <= RESET_VAL;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
		end
	end

	assign sync_out = sync_ff;
endmodule

// ==== src/fwp_core.sv ====
// write enable latch and per-sector protection command logic
`timescale 1ns/1ns
// How it works
// - program, erase, protect need latch set
// - opcode 06h sets latch at deselect
// - latch commands ignore bytes after opcode
// - latch command off-boundary aborts, latch unchanged
// - opcode 04h clears latch at deselect
// - write disable ends sequential program mode
// - one protect flag per sector, resets protected
// - flag zero allows program/erase, one blocks
// - opcode 36h protects, three address bytes
// - protect sets flag, clears latch
// - short or ragged protect aborts, clears latch
// - lock bit ignores protect, latch cleared
// - opcode 39h unprotects, three address bytes
// - unprotect clears flag and latch
// - lock bit ignores unprotect, latch cleared
// - program to protected sector aborts, latch cleared
module fwp_core
	import fwp_pkg::*;
#(
	parameter int SECTORS = NUM_SECTORS
) (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic nrst_in,
	// serial pins
	input wire logic spi_cs_n_in,
	input wire logic spi_sck_in,
	input wire logic spi_si_in,
	// status and control
	input wire logic protection_lock_bit_in,
	input wire logic seq_prog_active_in,
	output logic write_enable_latch_out,
	output logic [SECTORS-1:0] sector_protect_out,
	output logic seq_prog_exit_out,
	output logic prog_start_out,
	output logic erase_start_out,
	output logic [7:0] exec_opcode_out,
	output logic [ADDR_WIDTH-1:0] exec_addr_out
);
	// ****************************************
	// pin synchronisation
	// ****************************************
	logic [2:0] pins_sync;
	logic cs_n_s;
	logic sck_s;
	logic si_s;

	// select resets to its idle high level, so no false frame follows reset
	fwp_sync #(.WIDTH(3), .RESET_VAL(3'b100)) u_sync (
		.core_clk_in(core_clk_in),
		.nrst_in(nrst_in),
		.async_in({spi_cs_n_in, spi_sck_in, spi_si_in}),
		.sync_out(pins_sync)
	);
	assign cs_n_s = pins_sync[2];
	assign sck_s = pins_sync[1];
	assign si_s = pins_sync[0];

	// ****************************************
	// state
	// ****************************************
	fwp_state_e state_ff, nxt_state;
	logic sck_prev_ff, nxt_sck_prev;
	logic [5:0] bitcnt_ff, nxt_bitcnt;
	logic [7:0] opcode_ff, nxt_opcode;
	logic [ADDR_WIDTH-1:0] addr_ff, nxt_addr;
	logic wel_ff, nxt_wel;
	logic [SECTORS-1:0] prot_ff, nxt_prot;
	logic seq_exit_ff, nxt_seq_exit;
	logic prog_ff, nxt_prog;
	logic erase_ff, nxt_erase;
	logic [7:0] exec_op_ff, nxt_exec_op;
	logic [ADDR_WIDTH-1:0] exec_addr_ff, nxt_exec_addr;

	localparam logic [5:0] OPC_BITS = 6'(BYTE_BITS);
	localparam logic [5:0] FULL_BITS = 6'(BYTE_BITS * (1 + ADDR_BYTES));
	localparam logic [5:0] DATA_BITS = 6'(BYTE_BITS * (2 + ADDR_BYTES));
	localparam int SEC_W = $clog2(SECTORS);

	logic sck_rise;
	logic byte_aligned;
	logic opc_done;
	logic addr_done;
	logic sec_prot;
	logic [SEC_W-1:0] sec_idx;
	logic is_erase;
	logic is_chip;
	logic any_prot;

	always_comb begin
		sck_rise = sck_s && !sck_prev_ff;
		byte_aligned = (bitcnt_ff[2:0] == 3'h0);
		opc_done = (bitcnt_ff >= OPC_BITS);
		addr_done = (bitcnt_ff >= FULL_BITS);
		sec_idx = addr_ff[SECTOR_LSB +: SEC_W];
		sec_prot = prot_ff[sec_idx];
		any_prot = |prot_ff;
		is_erase = (opcode_ff == OP_ERASE_4K) || (opcode_ff == OP_ERASE_32K) ||
			(opcode_ff == OP_ERASE_64K);
		is_chip = (opcode_ff == OP_CHIP_ERASE_A) || (opcode_ff == OP_CHIP_ERASE_B);
	end

	// ****************************************
	// shifter and command decode
	// ****************************************
	always_comb begin
		nxt_state = state_ff;
		nxt_sck_prev = sck_s;
		nxt_bitcnt = bitcnt_ff;
		nxt_opcode = opcode_ff;
		nxt_addr = addr_ff;
		nxt_wel = wel_ff;
		nxt_prot = prot_ff;
		nxt_seq_exit = 1'b0;
		nxt_prog = 1'b0;
		nxt_erase = 1'b0;
		nxt_exec_op = exec_op_ff;
		nxt_exec_addr = exec_addr_ff;
		unique case (state_ff)
			FWP_IDLE: begin
				if (!cs_n_s) begin
					nxt_state = FWP_SHIFT;
					nxt_bitcnt = BITCNT_RESET;
					nxt_opcode = 8'h00;
					nxt_addr = '0;
				end
			end
			FWP_SHIFT: begin
				if (cs_n_s) begin
					nxt_state = FWP_DONE;
				end else if (sck_rise) begin
					if (!opc_done) begin
						nxt_opcode = {opcode_ff[6:0], si_s};
					end else if (!addr_done) begin
						nxt_addr = {addr_ff[ADDR_WIDTH-2:0], si_s};
					end
					// later bytes are dropped; past the data byte the count wraps from 47 back to 40
					if (addr_done) begin
						nxt_bitcnt = (bitcnt_ff == DATA_BITS + 6'h07) ? DATA_BITS :
							bitcnt_ff + 6'h01;
					end else begin
						nxt_bitcnt = bitcnt_ff + 6'h01;
					end
				end
			end
			FWP_DONE: begin
				nxt_state = FWP_IDLE;
				if (opc_done) begin
					unique case (opcode_ff)
						OP_WR_ENABLE: begin
							if (byte_aligned) nxt_wel = 1'b1;
						end
						OP_WR_DISABLE: begin
							if (byte_aligned) begin
								nxt_wel = 1'b0;
								nxt_seq_exit = seq_prog_active_in;
							end
						end
						OP_PROTECT: begin
							nxt_wel = 1'b0;
							if (wel_ff && addr_done && byte_aligned && !protection_lock_bit_in)
								nxt_prot[sec_idx] = 1'b1;
						end
						OP_UNPROTECT: begin
							nxt_wel = 1'b0;
							if (wel_ff && addr_done && byte_aligned && !protection_lock_bit_in)
								nxt_prot[sec_idx] = 1'b0;
						end
						OP_PAGE_PROG: begin
							// need address plus one data byte
							nxt_wel = 1'b0;
							if (wel_ff && byte_aligned && bitcnt_ff >= DATA_BITS && !sec_prot) begin
								nxt_prog = 1'b1;
								nxt_exec_op = opcode_ff;
								nxt_exec_addr = addr_ff;
							end
						end
						default: begin
							if (is_erase) begin
								nxt_wel = 1'b0;
								if (wel_ff && addr_done && byte_aligned && !sec_prot) begin
									nxt_erase = 1'b1;
									nxt_exec_op = opcode_ff;
									nxt_exec_addr = addr_ff;
								end
							end else if (is_chip) begin
								if (wel_ff && byte_aligned && any_prot) nxt_wel = 1'b0;
								if (wel_ff && byte_aligned && !any_prot) begin
									nxt_wel = 1'b0;
									nxt_erase = 1'b1;
									nxt_exec_op = opcode_ff;
									nxt_exec_addr = '0;
								end
							end
						end
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_ff <= FWP_IDLE;
			sck_prev_ff <= 1'b0;
			bitcnt_ff <= BITCNT_RESET;
			opcode_ff <= 8'h00;
			addr_ff <= '0;
			wel_ff <= WEL_RESET;
			prot_ff <= {SECTORS{PROTECT_RESET}};
			seq_exit_ff <= 1'b0;
			prog_ff <= 1'b0;
			erase_ff <= 1'b0;
			exec_op_ff <= 8'h00;
			exec_addr_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			sck_prev_ff <= nxt_sck_prev;
			bitcnt_ff <= nxt_bitcnt;
			opcode_ff <= nxt_opcode;
			addr_ff <= nxt_addr;
			wel_ff <= nxt_wel;
			prot_ff <= nxt_prot;
			seq_exit_ff <= nxt_seq_exit;
			prog_ff <= nxt_prog;
			erase_ff <= nxt_erase;
			exec_op_ff <= nxt_exec_op;
			exec_addr_ff <= nxt_exec_addr;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign write_enable_latch_out = wel_ff;
	assign sector_protect_out = prot_ff;
	assign seq_prog_exit_out = seq_exit_ff;
	assign prog_start_out = prog_ff;
	assign erase_start_out = erase_ff;
	assign exec_opcode_out = exec_op_ff;
	assign exec_addr_out = exec_addr_ff;
endmodule

// ==== verif/fwp_checker.sv ====
// checker: port assertions for the write latch and sector protect core
`timescale 1ns/1ns
module fwp_checker
	import fwp_pkg::*;
#(
	parameter int SECTORS = NUM_SECTORS
) (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic spi_cs_n_in,
	input wire logic protection_lock_bit_in,
	input wire logic seq_prog_active_in,
	input wire logic write_enable_latch_out,
	input wire logic [SECTORS-1:0] sector_protect_out,
	input wire logic seq_prog_exit_out,
	input wire logic prog_start_out,
	input wire logic erase_start_out,
	input wire logic [ADDR_WIDTH-1:0] exec_addr_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!nrst_in);
	sequence s_sel;
		!spi_cs_n_in[*4];
	endsequence
	sequence s_flag_move;
		$changed(sector_protect_out);
	endsequence
	property p_quiet;
		s_sel |-> $stable(write_enable_latch_out) && $stable(sector_protect_out);
	endproperty
	property p_prog_wel;
		prog_start_out |-> $past(write_enable_latch_out);
	endproperty
	property p_erase_wel;
		erase_start_out |-> $past(write_enable_latch_out);
	endproperty
	property p_prog_sect;
		prog_start_out |-> !sector_protect_out[exec_addr_out[19:16]];
	endproperty
	property p_erase_sect;
		erase_start_out |-> !sector_protect_out[exec_addr_out[19:16]];
	endproperty
	property p_flag_wel;
		s_flag_move |-> $past(write_enable_latch_out) && !$past(protection_lock_bit_in)
			&& !write_enable_latch_out;
	endproperty
	property p_flag_one;
		s_flag_move |-> $onehot(sector_protect_out ^ $past(sector_protect_out));
	endproperty
	property p_exit;
		seq_prog_exit_out |-> !write_enable_latch_out && $past(seq_prog_active_in);
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("latch or flags moved while selected");
	a_prog_wel: assert property (p_prog_wel)
		else $error("program without latch");
	a_erase_wel: assert property (p_erase_wel)
		else $error("erase without latch");
	a_prog_sect: assert property (p_prog_sect)
		else $error("program into protected sector");
	a_erase_sect: assert property (p_erase_sect)
		else $error("erase of protected sector");
	a_flag_wel: assert property (p_flag_wel)
		else $error("flag moved without latch, or latch kept");
	a_flag_one: assert property (p_flag_one)
		else $error("more than one flag moved");
	a_exit: assert property (p_exit)
		else $error("bad sequential mode exit");
endmodule
bind fwp_core fwp_checker #(.SECTORS(SECTORS)) i_fwp_checker (.core_clk_in, .nrst_in,
	.spi_cs_n_in, .protection_lock_bit_in, .seq_prog_active_in, .write_enable_latch_out,
	.sector_protect_out, .seq_prog_exit_out, .prog_start_out, .erase_start_out, .exec_addr_out);

// ==== verif/fwp_host.sv ====
// host model: serial frames into the core, clock idle low
`timescale 1ns/1ns
module fwp_host (
	input wire logic core_clk_in,
	output logic spi_cs_n_out,
	output logic spi_sck_out,
	output logic spi_si_out
);
	initial begin
		spi_cs_n_out = 1'b1;
		spi_sck_out = 1'b0;
		spi_si_out = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk_in);
	endtask
	task automatic send(input logic [47:0] d, input int n);
		tick(1);
		spi_cs_n_out = 1'b0;
		for (int i = 0; i < n; i++) begin
			spi_si_out = d[47-i];
			tick(4);
			spi_sck_out = 1'b1;
			tick(4);
			spi_sck_out = 1'b0;
		end
		tick(4);
		spi_cs_n_out = 1'b1;
		spi_si_out = ~spi_si_out;
		tick(10);
	endtask
endmodule

// ==== verif/testbench.sv ====
// testbench: command scenarios for the write latch and sector protect core
`timescale 1ns/1ns
module testbench;
	import fwp_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic cs_n, sck, si, write_enable_latch, ex, pg, er;
	logic lock = 1'b0;
	logic seq = 1'b0;
	logic [15:0] fl;
	logic [7:0] op;
	logic [23:0] ad;
	int miscompares = 0;
	int comparisons = 0;
	int n_pg = 0;
	int n_er = 0;
	int n_ex = 0;
	initial forever #20 clk = ~clk;
	always @(posedge clk) begin
		n_pg += (pg === 1'b1);
		n_er += (er === 1'b1);
		n_ex += (ex === 1'b1);
	end
	fwp_core i_fwp_core (.core_clk_in(clk), .nrst_in(nrst), .spi_cs_n_in(cs_n),
		.spi_sck_in(sck), .spi_si_in(si), .protection_lock_bit_in(lock),
		.seq_prog_active_in(seq), .write_enable_latch_out(write_enable_latch), .sector_protect_out(fl),
		.seq_prog_exit_out(ex), .prog_start_out(pg), .erase_start_out(er),
		.exec_opcode_out(op), .exec_addr_out(ad));
	fwp_host i_fwp_host (.core_clk_in(clk), .spi_cs_n_out(cs_n), .spi_sck_out(sck),
		.spi_si_out(si));
	task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic st(input logic w, input logic [15:0] f);
		chk("latch", 24'(w), 24'(write_enable_latch));
		chk("flags", 24'(f), 24'(fl));
	endtask
	task automatic cmd(input logic [47:0] d, input int n);
		i_fwp_host.send(d, n);
	endtask
	task automatic wren();
		cmd({OP_WR_ENABLE, 40'h0}, 8);
	endtask
	task automatic t_latch();
		cmd({OP_WR_ENABLE, 40'hff}, 16);
		st(1'b1, 16'hffff);
		cmd({OP_WR_DISABLE, 40'h0}, 7);
		st(1'b1, 16'hffff);
		seq = 1'b1;
		cmd({OP_WR_DISABLE, 40'h0}, 8);
		st(1'b0, 16'hffff);
		chk("exit", 24'h1, 24'(n_ex));
		seq = 1'b0;
		cmd({OP_WR_ENABLE, 40'h0}, 12);
		st(1'b0, 16'hffff);
	endtask
	task automatic t_sector();
		wren();
		cmd({OP_UNPROTECT, 24'h05abcd, 16'h0}, 32);
		st(1'b0, 16'hffdf);
		cmd({OP_PROTECT, 24'h050000, 16'h0}, 32);
		st(1'b0, 16'hffdf);
		wren();
		cmd({OP_PROTECT, 24'h050000, 16'h0}, 24);
		st(1'b0, 16'hffdf);
		wren();
		cmd({OP_PAGE_PROG, 24'h050010, 16'h5a00}, 40);
		chk("prog", 24'h1, 24'(n_pg));
		chk("addr", 24'h050010, ad);
		chk("opcode", 24'(OP_PAGE_PROG), 24'(op));
		wren();
		cmd({OP_ERASE_4K, 24'h051000, 16'h0}, 32);
		chk("erase", 24'h1, 24'(n_er));
		chk("addr", 24'h051000, ad);
		chk("opcode", 24'(OP_ERASE_4K), 24'(op));
		wren();
		cmd({OP_PAGE_PROG, 24'h060010, 16'h5a00}, 40);
		chk("prog", 24'h1, 24'(n_pg));
		st(1'b0, 16'hffdf);
	endtask
	task automatic t_lock();
		lock = 1'b1;
		wren();
		cmd({OP_PROTECT, 24'h050000, 16'h0}, 32);
		st(1'b0, 16'hffdf);
		wren();
		cmd({OP_UNPROTECT, 24'h030000, 16'h0}, 32);
		st(1'b0, 16'hffdf);
		lock = 1'b0;
		wren();
		cmd({OP_PROTECT, 24'h05ffff, 16'h1234}, 48);
		st(1'b0, 16'hffff);
		wren();
		cmd({OP_ERASE_64K, 24'h050000, 16'h0}, 32);
		chk("erase", 24'h1, 24'(n_er));
	endtask
	task automatic t_chip();
		wren();
		cmd({OP_CHIP_ERASE_A, 40'h0}, 8);
		chk("erase", 24'h1, 24'(n_er));
		st(1'b0, 16'hffff);
		for (int i = 0; i < 16; i++) begin
			wren();
			cmd({OP_UNPROTECT, 4'h0, 4'(i), 32'h0}, 32);
		end
		st(1'b0, 16'h0000);
		cmd({OP_ERASE_32K, 24'h0a8000, 16'h0}, 32);
		chk("erase", 24'h1, 24'(n_er));
		cmd({OP_PAGE_PROG, 24'h030000, 16'h5a00}, 40);
		chk("prog", 24'h1, 24'(n_pg));
		wren();
		cmd({OP_CHIP_ERASE_B, 40'h0}, 16);
		chk("erase", 24'h2, 24'(n_er));
		chk("opcode", 24'(OP_CHIP_ERASE_B), 24'(op));
		chk("addr", 24'h0, ad);
		st(1'b0, 16'h0000);
		wren();
		cmd({OP_ERASE_32K, 24'h0a8000, 16'h0}, 32);
		chk("erase", 24'h3, 24'(n_er));
		chk("opcode", 24'(OP_ERASE_32K), 24'(op));
		chk("addr", 24'h0a8000, ad);
	endtask
	task automatic complete_run();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(negedge clk);
		nrst = 1'b1;
		repeat (4) @(negedge clk);
		st(1'b0, 16'hffff);
		t_latch();
		t_sector();
		t_lock();
		t_chip();
		complete_run();
	end
endmodule
